/* hdl/csb_slave.sv */
// charger bus slave: word read/write, status latches and alert timer
// assumes scl/sda pins from an outside host and status from same clock
// Summary of operation
// - ack read address only after quick repeated start
// - read returns at most two data bytes, one if the host nacks the first
// - start or stop aborts any transfer phase
// - any stop returns the machine to idle
// - idle ignores everything until a start
// - only valid commands select write or read data
// - read phase sends current register contents
// - foreign slave address gets no acknowledge
// - reserved command is neither acked nor stored
// - status bit change raises the alert output
// - charge overcurrent bit latches until status read
// - adapter overcurrent bit latches until status read
// - own addresses are 12h write, 13h read
// - valid commands 12h,13h,14h,15h,3Fh only
// - alert rises 6 to 10 ms after change
// - word write commits after second data ack
`timescale 1ns/10ps
module csb_slave
    import csb_pkg::*;
#(
    parameter int RS_CYC = RS_HIGH_MAX_CYC,
    parameter int ALERT_CYC_P = ALERT_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [15:0] status_in,
    input wire logic chg_oc_det,
    input wire logic adp_oc_det,
    output logic alert,
    output csb_ctrl_t ctrl
);

    localparam logic [TMR_W-1:0] RS_LIM = TMR_W'(RS_CYC);
    localparam logic [TMR_W-1:0] ALM_LAST = TMR_W'(ALERT_CYC_P - 1);

    typedef struct packed {
        csb_state_t st;
        csb_state_t nxt;
        logic scl_p;
        logic sda_p;
        logic [7:0] sh;
        logic [3:0] cnt;
        logic byte_i;
        logic rs_ok;
        logic cmd_ok;
        logic [7:0] cmd;
        logic [7:0] lo;
        logic [7:0] tx;
        logic [15:0] rd_word;
        logic rack_ok;
        logic commit;
        logic sda_oe;
        logic [TMR_W-1:0] hi_cnt;
        csb_ctrl_t regs;
        logic chg_oc;
        logic adp_oc;
        logic [15:0] stat_prev;
        logic alm_run;
        logic [TMR_W-1:0] alm_cnt;
        logic alert;
    } csb_core_t;

    csb_core_t q;
    csb_core_t d;
    logic [1:0] pv;
    logic scl;
    logic sda;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic [15:0] sw;
    logic [15:0] rd_w;
    logic stat_rd;
    logic commit_now;
    logic byte_end;

    // ==========================================================
    // pin conditioning
    csb_pin_sync #(.W(2)) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .pin_in({scl_in, sda_in}),
        .pin_val(pv)
    );

    // edge and condition decode on the filtered lines
    assign scl = pv[1];
    assign sda = pv[0];
    assign rise = scl && !q.scl_p;
    assign fall = !scl && q.scl_p;
    assign start = scl && q.scl_p && q.sda_p && !sda;
    assign stop = scl && q.scl_p && !q.sda_p && sda;
    assign byte_end = fall && q.cnt == BIT_LAST;
    assign commit_now = fall && q.st == ST_ACK && q.commit;

    // status word with the latched overcurrent bits in place
    always_comb begin
        sw = status_in;
        sw[CHG_OC_BIT] = q.chg_oc;
        sw[ADP_OC_BIT] = q.adp_oc;
    end

    // register selected by the stored command
    always_comb begin
        unique case (q.cmd)
            CMD_MODE: rd_w = q.regs.mode;
            CMD_STATUS: rd_w = sw;
            CMD_CHG_CUR: rd_w = q.regs.chg_cur;
            CMD_CHG_VOLT: rd_w = q.regs.chg_volt;
            default: rd_w = q.regs.in_cur;
        endcase
    end

    // status is read when its low byte is loaded for sending
    assign stat_rd = fall && q.st == ST_ACK && q.nxt == ST_RDATA &&
        q.cmd == CMD_STATUS;

    // ==========================================================
    // protocol, latches and alert
    always_comb begin
        d = q;
        d.scl_p = scl;
        d.sda_p = sda;
        // clock-high timer, restarted at every rising edge
        if (rise) begin
            d.hi_cnt = '0;
        end else if (scl && !(&q.hi_cnt)) begin
            d.hi_cnt = q.hi_cnt + 1'b1;
        end
        if (stop) begin
            d.st = ST_IDLE;
            d.sda_oe = 1'b0;
            d.commit = 1'b0;
            d.cmd_ok = 1'b0;
            d.rs_ok = 1'b0;
        end else if (start) begin
            // a start inside a transaction is a repeated start
            d.rs_ok = q.st != ST_IDLE && q.hi_cnt < RS_LIM;
            d.st = ST_ADDR;
            d.cnt = '0;
            d.sda_oe = 1'b0;
            d.commit = 1'b0;
        end else if (q.st == ST_IDLE) begin
            d.st = ST_IDLE;
        end else if (rise) begin
            if ((q.st == ST_ADDR || q.st == ST_CMD || q.st == ST_WDATA)
                && q.cnt != BIT_LAST) begin
                d.sh = {q.sh[6:0], sda};
                d.cnt = q.cnt + 1'b1;
            end
            if (q.st == ST_RACK) begin
                d.rack_ok = !sda;
            end
        end else if (fall) begin
            unique case (q.st)
                ST_ADDR: begin
                    if (byte_end) begin
                        d.cnt = '0;
                        d.st = ST_WAIT;
                        if (q.sh == WRITE_SLAVE_ADDRESS) begin
                            d.st = ST_ACK;
                            d.nxt = ST_CMD;
                            d.sda_oe = 1'b1;
                            d.cmd_ok = 1'b0;
                        end else if (q.sh == READ_SLAVE_ADDRESS &&
                            q.rs_ok && q.cmd_ok) begin
                            d.st = ST_ACK;
                            d.nxt = ST_RDATA;
                            d.sda_oe = 1'b1;
                        end
                    end
                end
                ST_CMD: begin
                    if (byte_end) begin
                        d.cnt = '0;
                        d.st = ST_WAIT;
                        if (csb_cmd_ok(q.sh)) begin
                            d.cmd = q.sh;
                            d.cmd_ok = 1'b1;
                            d.sda_oe = 1'b1;
                            d.st = ST_ACK;
                            d.nxt = ST_WDATA;
                            d.byte_i = 1'b0;
                        end
                    end
                end
                ST_WDATA: begin
                    if (byte_end) begin
                        d.cnt = '0;
                        d.sda_oe = 1'b1;
                        d.st = ST_ACK;
                        if (!q.byte_i) begin
                            d.lo = q.sh;
                            d.byte_i = 1'b1;
                            d.nxt = ST_WDATA;
                        end else begin
                            d.commit = 1'b1;
                            d.nxt = ST_WAIT;
                        end
                    end
                end
                ST_ACK: begin
                    d.sda_oe = 1'b0;
                    d.st = q.nxt;
                    // commit only at the end of the second data ack
                    if (q.commit) begin
                        d.commit = 1'b0;
                        unique case (q.cmd)
                            CMD_MODE: d.regs.mode = {q.sh, q.lo};
                            CMD_CHG_CUR: d.regs.chg_cur = {q.sh, q.lo};
                            CMD_CHG_VOLT: d.regs.chg_volt = {q.sh, q.lo};
                            CMD_IN_CUR: d.regs.in_cur = {q.sh, q.lo};
                            default: d.regs = q.regs; // status is read-only
                        endcase
                    end
                    if (q.nxt == ST_RDATA) begin
                        // snapshot the word; low byte goes first
                        d.rd_word = rd_w;
                        d.byte_i = 1'b0;
                        d.sda_oe = !rd_w[7];
                        d.tx = {rd_w[6:0], 1'b0};
                        d.cnt = 4'h1;
                    end
                end
                ST_RDATA: begin
                    if (q.cnt != BIT_LAST) begin
                        d.sda_oe = !q.tx[7];
                        d.tx = {q.tx[6:0], 1'b0};
                        d.cnt = q.cnt + 1'b1;
                    end else begin
                        d.sda_oe = 1'b0;
                        d.st = ST_RACK;
                        d.rack_ok = 1'b0;
                    end
                end
                ST_RACK: begin
                    d.st = ST_WAIT;
                    if (q.rack_ok && !q.byte_i) begin
                        d.byte_i = 1'b1;
                        d.st = ST_RDATA;
                        d.sda_oe = !q.rd_word[15];
                        d.tx = {q.rd_word[14:8], 1'b0};
                        d.cnt = 4'h1;
                    end
                end
                default: begin
                    d.sda_oe = 1'b0;
                end
            endcase
        end
        // overcurrent latches: a new event wins over the read clear
        if (chg_oc_det) begin
            d.chg_oc = 1'b1;
        end else if (stat_rd) begin
            d.chg_oc = 1'b0;
        end
        if (adp_oc_det) begin
            d.adp_oc = 1'b1;
        end else if (stat_rd) begin
            d.adp_oc = 1'b0;
        end
        // alert delay timer, started by a status change while it is stopped and alert is low
        d.stat_prev = sw;
        if (sw != q.stat_prev && !q.alm_run && !q.alert) begin
            d.alm_run = 1'b1;
            d.alm_cnt = '0;
        end else if (q.alm_run) begin
            d.alm_cnt = q.alm_cnt + 1'b1;
            if (q.alm_cnt == ALM_LAST) begin
                d.alm_run = 1'b0;
                d.alert = 1'b1;
            end
        end
        if (stat_rd && !(q.alm_run && q.alm_cnt == ALM_LAST)) begin
            d.alert = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            q <= '0;
            q.st <= ST_IDLE;
            q.nxt <= ST_IDLE;
            q.scl_p <= 1'b1;
            q.sda_p <= 1'b1;
            q.regs <= '{REG_RST, REG_RST, REG_RST, REG_RST};
        end else begin
            q <= d;
        end
    end

    // open drain: the line is only ever pulled low
    assign sda_out = 1'b0;
    assign sda_oe = q.sda_oe;
    assign alert = q.alert;
    assign ctrl = q.regs;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    idle_ignore_a: assert property (q.st == ST_IDLE && !start |=>
        q.st == ST_IDLE && !q.sda_oe) else $error("idle not held");
    stop_idle_a: assert property (stop |=> q.st == ST_IDLE)
        else $error("stop did not reach idle");
    start_abort_a: assert property (start |=>
        q.st == ST_ADDR && !q.sda_oe && !q.commit)
        else $error("start did not abort");
    foreign_nack_a: assert property (byte_end && q.st == ST_ADDR &&
        q.sh != WRITE_SLAVE_ADDRESS && q.sh != READ_SLAVE_ADDRESS
        |=> !q.sda_oe && q.st == ST_WAIT) else $error("foreign acked");
    read_addr_a: assert property (byte_end && q.st == ST_ADDR &&
        q.sh == READ_SLAVE_ADDRESS |=> q.sda_oe == $past(q.rs_ok &&
        q.cmd_ok)) else $error("read address ack wrong");
    rsvd_cmd_a: assert property (byte_end && q.st == ST_CMD &&
        !csb_cmd_ok(q.sh) |=> !q.sda_oe && $stable(q.cmd))
        else $error("reserved command taken");
    cmd_store_a: assert property (byte_end && q.st == ST_CMD &&
        csb_cmd_ok(q.sh) |=> q.sda_oe && q.cmd_ok && q.cmd == $past(q.sh))
        else $error("valid command not stored");
    commit_a: assert property ($changed(q.regs) |->
        $past(commit_now)) else $error("write outside commit");
    low_first_a: assert property (stat_rd || (fall && q.st == ST_ACK &&
        q.nxt == ST_RDATA) |=> q.rd_word == $past(rd_w) &&
        q.sda_oe == !q.rd_word[7]) else $error("low byte not first");
    two_byte_a: assert property (fall && q.st == ST_RACK && q.byte_i
        |=> q.st == ST_WAIT ##1 !q.sda_oe) else $error("third byte sent");
    chg_hold_a: assert property (q.chg_oc && !stat_rd |=> q.chg_oc)
        else $error("charge latch lost");
    adp_hold_a: assert property (q.adp_oc && !stat_rd |=> q.adp_oc)
        else $error("adapter latch lost");
    alert_time_a: assert property ($rose(q.alert) |->
        $past(q.alm_cnt) == ALM_LAST && $past(q.alm_run))
        else $error("alert timing wrong");
    wait_release_a: assert property (q.st == ST_WAIT |-> !q.sda_oe)
        else $error("line driven while waiting");

    word_read_c: cover property (fall && q.st == ST_RACK && q.byte_i);
    word_write_c: cover property (commit_now);
    alert_c: cover property ($rose(q.alert));
    rsvd_cmd_c: cover property (byte_end && q.st == ST_CMD &&
        !csb_cmd_ok(q.sh));

endmodule : csb_slave

/* hdl/csb_pkg.sv */
// constants, carriers and decoders for the charger bus slave
// assumes a single 200 MHz clock domain and a bus host on two pins
package csb_pkg;

    // ==========================================================
    // timing
    localparam int CLK_MHZ = 200;
    localparam int RS_HIGH_MAX_US = 50;
    // longest time rounds down to whole cycles
    localparam int RS_HIGH_MAX_CYC = RS_HIGH_MAX_US * CLK_MHZ;
    localparam int ALERT_MIN_MS = 6;
    localparam int ALERT_MAX_MS = 10;
    // aim at the middle of the window for margin on both sides
    localparam int ALERT_CYC =
        (ALERT_MIN_MS + ALERT_MAX_MS) / 2 * CLK_MHZ * 1000;
    localparam int TMR_W = 24;

    // ==========================================================
    // addresses, commands, fields
    localparam logic [7:0] WRITE_SLAVE_ADDRESS = 8'h12;
    localparam logic [7:0] READ_SLAVE_ADDRESS = 8'h13;
    localparam logic [7:0] CMD_MODE = 8'h12;
    localparam logic [7:0] CMD_STATUS = 8'h13;
    localparam logic [7:0] CMD_CHG_CUR = 8'h14;
    localparam logic [7:0] CMD_CHG_VOLT = 8'h15;
    localparam logic [7:0] CMD_IN_CUR = 8'h3f;
    localparam int CHG_OC_BIT = 0;
    localparam int ADP_OC_BIT = 1;
    localparam logic [15:0] REG_RST = 16'h0000;
    localparam logic [3:0] BIT_LAST = 4'h8;

    // ==========================================================
    // types
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_CMD, ST_WDATA, ST_ACK, ST_RDATA, ST_RACK,
        ST_WAIT
    } csb_state_t;

    // control words written by the host
    typedef struct packed {
        logic [15:0] mode;
        logic [15:0] chg_cur;
        logic [15:0] chg_volt;
        logic [15:0] in_cur;
    } csb_ctrl_t;

    // true for a non-reserved command code
    function automatic logic csb_cmd_ok(input logic [7:0] c);
        return c == CMD_MODE || c == CMD_STATUS || c == CMD_CHG_CUR ||
            c == CMD_CHG_VOLT || c == CMD_IN_CUR;
    endfunction : csb_cmd_ok

endpackage : csb_pkg

/* hdl/csb_pin_sync.sv */
// three-stage pin synchroniser with agreement filter
// assumes pins are asynchronous to clk; output changes only on agreement
`timescale 1ns/10ps
module csb_pin_sync #(
    parameter int W = 2
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_val
);

    typedef struct packed {
        logic [W-1:0] ff1;
        logic [W-1:0] ff2;
        logic [W-1:0] ff3;
        logic [W-1:0] val;
    } csb_sync_t;

    csb_sync_t q;
    csb_sync_t d;

    // ==========================================================
    // chain; ff1 feeds only ff2 so metastability stays contained
    always_comb begin
        d = q;
        d.ff1 = pin_in;
        d.ff2 = q.ff1;
        d.ff3 = q.ff2;
        for (int i = 0; i < W; i++) begin
            if (q.ff2[i] == q.ff3[i]) begin
                d.val[i] = q.ff3[i];
            end
        end
    end

    // pins idle high, so reset to high avoids a false edge
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            q <= '{default: '1};
        end else begin
            q <= d;
        end
    end

    assign pin_val = q.val;

endmodule : csb_pin_sync

/* testbench/csb_host.sv */
// bus host model: owns the bus clock and pulls the data line low
// assumes a pull-up on the data wire and the bench clock for pacing
`timescale 1ns/10ps
module csb_host
    import csb_pkg::*;
#(
    parameter int Q = 8
) (
    input wire logic clk,
    input wire logic sda_wire,
    output logic scl,
    output logic sda_drv
);
    // ==========================================================
    // idle bus: clock stands high, data released
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic gap(input int n);
        repeat (n) @(posedge clk);
    endtask : gap

    // one bit; data moves only while the clock is low
    task automatic bit_io(input logic b, output logic s);
        scl <= 1'b0;
        gap(Q);
        sda_drv <= b;
        gap(Q);
        scl <= 1'b1;
        gap(Q);
        s = sda_wire;
        gap(Q);
    endtask : bit_io

    // data falls while the clock stands high
    task automatic send_start;
        sda_drv <= 1'b0;
        gap(2 * Q);
    endtask : send_start

    // hold sets how long the clock stays high before data falls
    task automatic send_rstart(input int hold);
        scl <= 1'b0;
        gap(Q);
        sda_drv <= 1'b1;
        gap(Q);
        scl <= 1'b1;
        gap(hold);
        sda_drv <= 1'b0;
        gap(2 * Q);
    endtask : send_rstart

    // also the way back to idle when the host loses its place
    task automatic send_stop;
        scl <= 1'b0;
        gap(Q);
        sda_drv <= 1'b0;
        gap(Q);
        scl <= 1'b1;
        gap(2 * Q);
        sda_drv <= 1'b1;
        gap(2 * Q);
    endtask : send_stop

    // msb first, then the ninth bit released for the device answer
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], s);
        end
        bit_io(1'b1, ack);
    endtask : wbyte

    // a low answer bit acknowledges the byte
    task automatic rbyte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(nack, s);
    endtask : rbyte
endmodule : csb_host

/* testbench/csb_slave_bench.sv */
// self-checking bench of the charger bus slave with a host model
// assumes the design package and a pull-up on the data wire
`timescale 1ns/10ps
module csb_slave_bench
    import csb_pkg::*;
;
    // short counts keep the run brief; a bus bit is 4*Q clocks, 160 ns
    localparam int RS = 200;
    localparam int AL = 100;
    localparam int Q = 8;
    localparam logic [7:0] WCMD [4] = '{8'h12, 8'h14, 8'h15, 8'h3f};
    localparam logic [7:0] RSV [5] = '{8'h00, 8'h11, 8'h16, 8'h3e, 8'hff};
    logic clk, rst_b, scl, sda_drv, sda_wire, sda_out, sda_oe, alert;
    logic chg_oc_det, adp_oc_det;
    logic [15:0] status_in, s;
    logic [7:0] f;
    logic a;
    csb_ctrl_t ctrl, exp_ctrl;
    int n_mismatch = 0;
    int comparisons = 0;
    int seed = 32'hfdf6;

    // ==========================================================
    // clock, open-drain wire and the two parties
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    assign sda_wire = sda_drv & ~(sda_oe & ~sda_out);
    csb_host #(.Q(Q)) u_host (.clk(clk), .sda_wire(sda_wire),
        .scl(scl), .sda_drv(sda_drv));
    csb_slave #(.RS_CYC(RS), .ALERT_CYC_P(AL)) u_dut (.clk(clk),
        .rst_b(rst_b), .scl_in(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe(sda_oe), .status_in(status_in),
        .chg_oc_det(chg_oc_det), .adp_oc_det(adp_oc_det),
        .alert(alert), .ctrl(ctrl));

    // ==========================================================
    // comparison, verdict and expectation helpers
    task automatic check(input string nm, input logic [63:0] seen,
        input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic finish_test;
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test

    function automatic logic valid_cmd(input logic [7:0] c);
        return c inside {8'h12, 8'h13, 8'h14, 8'h15, 8'h3f};
    endfunction : valid_cmd

    function automatic logic [15:0] field(input logic [7:0] c);
        case (c)
            8'h12: return exp_ctrl.mode;
            8'h14: return exp_ctrl.chg_cur;
            8'h15: return exp_ctrl.chg_volt;
            default: return exp_ctrl.in_cur;
        endcase
    endfunction : field

    // word write of n data bytes, low byte first, then a stop
    task automatic wr(input logic [7:0] c, input logic [15:0] d,
        input int n);
        logic ack;
        u_host.send_start();
        u_host.wbyte(WRITE_SLAVE_ADDRESS, ack);
        check("write address ack", ack, 1'b0);
        u_host.wbyte(c, ack);
        check("command ack", ack, !valid_cmd(c));
        if (n > 0) u_host.wbyte(d[7:0], ack);
        if (n > 1) u_host.wbyte(d[15:8], ack);
        u_host.send_stop();
        if (n > 1 && valid_cmd(c)) begin
            case (c)
                8'h12: exp_ctrl.mode = d;
                8'h14: exp_ctrl.chg_cur = d;
                8'h15: exp_ctrl.chg_volt = d;
                8'h3f: exp_ctrl.in_cur = d;
                default: ; // status is acked but read-only
            endcase
        end
        check("control words", ctrl, exp_ctrl);
    endtask : wr

    // full word read; the host acks the first byte, nacks the second
    task automatic rd(input logic [7:0] c, input int hold,
        input logic [15:0] e);
        logic ack, ok;
        logic [15:0] d;
        logic [7:0] x;
        ok = valid_cmd(c) && hold < RS;
        u_host.send_start();
        u_host.wbyte(WRITE_SLAVE_ADDRESS, ack);
        u_host.wbyte(c, ack);
        u_host.send_rstart(hold);
        u_host.wbyte(READ_SLAVE_ADDRESS, ack);
        check("read address ack", ack, !ok);
        if (ok) begin
            u_host.rbyte(1'b0, d[7:0]);
            u_host.rbyte(1'b1, d[15:8]);
            check("read word", d, e);
            u_host.rbyte(1'b1, x);
            check("bits after nack", x, 8'hff);
        end
        u_host.send_stop();
    endtask : rd

    // ==========================================================
    // hang guard, reckoned from some 38k clocks of traffic
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        finish_test();
    end

    // ==========================================================
    // main sequence
    initial begin
        rst_b = 1'b0;
        status_in = 16'h0000;
        chg_oc_det = 1'b0;
        adp_oc_det = 1'b0;
        exp_ctrl = '0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        repeat (10) @(posedge clk);
        // own address clocked without a start must go unanswered
        u_host.wbyte(WRITE_SLAVE_ADDRESS, a);
        check("idle address ack", a, 1'b1);
        // back-to-back writes then read-backs of every control word
        foreach (WCMD[i]) wr(WCMD[i], 16'($random(seed)), 2);
        foreach (WCMD[i]) rd(WCMD[i], Q, field(WCMD[i]));
        // status is a valid code but a write to it changes nothing
        wr(CMD_STATUS, 16'($random(seed)), 2);
        // reserved codes at the edges of the valid ones
        foreach (RSV[i]) begin
            wr(RSV[i], 16'($random(seed)), 2);
            rd(RSV[i], Q, 16'h0000);
        end
        // foreign addresses, one drawn at random
        for (int i = 0; i < 3; i++) begin
            f = (i == 0) ? 8'h10 : (i == 1) ? 8'h92 : 8'($random(seed));
            if (f[7:1] == 7'h09) f = f ^ 8'h40;
            u_host.send_start();
            u_host.wbyte(f, a);
            check("foreign address ack", a, 1'b1);
            u_host.send_stop();
        end
        // stop after one data byte drops the write; read back further down
        wr(CMD_CHG_CUR, 16'($random(seed)), 1);
        // a repeated start after one data byte drops the write as well
        u_host.send_start();
        u_host.wbyte(WRITE_SLAVE_ADDRESS, a);
        u_host.wbyte(CMD_CHG_VOLT, a);
        u_host.wbyte(8'($random(seed)), a);
        u_host.send_rstart(Q);
        u_host.send_stop();
        check("write cut by start", ctrl, exp_ctrl);
        rd(CMD_CHG_CUR, Q, field(CMD_CHG_CUR));
        // slow repeated start refuses the read; host redoes it
        rd(CMD_MODE, 250, 16'h0000);
        rd(CMD_MODE, Q, field(CMD_MODE));
        // status change raises the alert after the set delay
        s = (16'($random(seed)) & 16'hfffc) | 16'h0100;
        @(posedge clk);
        status_in <= s;
        repeat (AL / 2) @(negedge clk);
        check("alert early", alert, 1'b0);
        repeat (AL) @(negedge clk);
        check("alert raised", alert, 1'b1);
        // one-cycle detect pulses must be held until a status read
        @(posedge clk);
        chg_oc_det <= 1'b1;
        @(posedge clk);
        chg_oc_det <= 1'b0;
        rd(CMD_STATUS, Q, s | 16'h0001);
        @(posedge clk);
        adp_oc_det <= 1'b1;
        @(posedge clk);
        adp_oc_det <= 1'b0;
        rd(CMD_STATUS, Q, s | 16'h0002);
        rd(CMD_STATUS, Q, s);
        finish_test();
    end
endmodule : csb_slave_bench
